//--- src/wspg_regs.svh
// Operation
// - adapter wake enabled: leave off on adapter edge into its active level
// - cover wake enabled: leave off on cover edge into its active level
// - wake cover polarity bit: 0 makes cover high active, 1 low active
// - interrupt cover polarity bit: 1 makes cover high active for flagging
// - adapter wake status set when adapter event caused the wake
// - cover wake status set when cover event caused the wake
// - button wake status set when power button caused the wake
// - thermal status set when a thermal event forces shutdown
// - each status bit reads back and clears on writing one
// - adapter flag: pin low on adapter low (polarity 0) or high (1)
// - cover flag: pin low on cover low (polarity 0) or high (1)
// - gpio flag: enabled gpio drives pin low while at its selected level
// - over-temperature flag: pin flags monitor over-temperature events
// - small converter flag: pin low on any of three over-currents
// - main converter flag: pin low on main converter over-current
// - mode 0: pin is rail-good indicator, high once all rails good
// - mode 1: pin held low 100 us after power-up, then event flag
`ifndef WSPG_REGS_SVH
`define WSPG_REGS_SVH
// ==========================================================
// register offsets and reset values
`define WSPG_ADDR_WAKE_CFG   8'h77
`define WSPG_ADDR_WAKE_STAT  8'h78
`define WSPG_ADDR_PG_CFG     8'h79
`define WSPG_WAKE_CFG_RST    4'h3
`define WSPG_WAKE_STAT_RST   4'h0
`define WSPG_PG_CFG_RST      7'h60
// ==========================================================
// field positions
`define WSPG_WC_ADAPTER      0
`define WSPG_WC_COVER        1
`define WSPG_WC_COVER_POL    2
`define WSPG_WS_ADAPTER      0
`define WSPG_WS_COVER        1
`define WSPG_WS_BUTTON       2
`define WSPG_WS_THERMAL      3
`define WSPG_PG_ADAPTER      0
`define WSPG_PG_COVER        1
`define WSPG_PG_GPIO         2
`define WSPG_PG_OVERTEMP     3
`define WSPG_PG_SMALL_OC     4
`define WSPG_PG_MAIN_OC      5
`define WSPG_PG_MODE         6
// ==========================================================
// timing
`define WSPG_CLK_PERIOD_NS   100
`define WSPG_PG_HOLD_US      100
`define WSPG_PG_HOLD_CYC     ((`WSPG_PG_HOLD_US * 1000) / `WSPG_CLK_PERIOD_NS)
`endif

//--- src/wspg_pkg.sv
package wspg_pkg;
	typedef enum logic [1:0]
	{
		WSPG_OFF  = 2'b00,
		WSPG_RAIL = 2'b01,
		WSPG_HOLD = 2'b10,
		WSPG_FLAG = 2'b11
	} wspg_state_type;

	// internal monitor events, all on mclk
	typedef struct packed
	{
		logic       main_oc;
		logic [2:0] small_oc;
		logic       overtemp;
	} wspg_mon_type;

	// gpio interrupt settings from the gpio block
	typedef struct packed
	{
		logic [7:0] int_en;
		logic [7:0] pol;
	} wspg_gpio_cfg_type;
endpackage

//--- src/wspg_top.sv
`timescale 1ns/1ps
`include "wspg_regs.svh"
module wspg_top
	import wspg_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	output logic [7:0]             reg_rd_data,
	input  wire logic              adapter_present_input,
	input  wire logic              cover_switch_input,
	input  wire logic              power_button,
	input  wire logic [7:0]        gpio_pin,
	input  wire logic              adapter_polarity,
	input  wire logic              int_cover_polarity,
	input  wire wspg_gpio_cfg_type gpio_cfg,
	input  wire wspg_mon_type      mon,
	input  wire logic              thermal_shutdown,
	input  wire logic              device_off,
	input  wire logic              rails_good,
	output logic                   wake_request,
	output logic                   power_good_pin
);
	localparam logic [9:0] HOLD_LAST = 10'(`WSPG_PG_HOLD_CYC - 1);

	// ==========================================================
	// pin synchronisers
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [10:0] prev;
	logic [10:0] next_sync1;
	logic [10:0] next_sync2;
	logic [10:0] next_prev;

	always_comb
	begin
		next_sync1 = {gpio_pin, power_button, cover_switch_input, adapter_present_input};
		next_sync2 = sync1;
		next_prev  = sync2;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			sync1 <= 11'h000;
			sync2 <= 11'h000;
			prev  <= 11'h000;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			prev  <= next_prev;
		end
	end

	logic       adp;
	logic       cov;
	logic       btn;
	logic [7:0] gpio;
	assign adp  = sync2[0];
	assign cov  = sync2[1];
	assign btn  = sync2[2];
	assign gpio = sync2[10:3];

	// ==========================================================
	// registers
	logic [3:0] wake_source_config;
	logic [3:0] wake_cause_status;
	logic [6:0] power_good_pin_config;
	logic [3:0] next_wake_cfg;
	logic [3:0] next_wake_stat;
	logic [6:0] next_pg_cfg;
	logic [7:0] next_rd_data;
	logic       next_wake_req;

	logic adp_act;
	logic cov_act;
	logic adp_wake;
	logic cov_wake;
	logic btn_wake;
	logic any_wake;

	// polarity 0 flags adapter removal, so wake is the opposite level
	assign adp_act  = ~adapter_polarity;
	assign cov_act  = ~wake_source_config[`WSPG_WC_COVER_POL];
	assign adp_wake = wake_source_config[`WSPG_WC_ADAPTER] & (adp == adp_act)
		& (prev[0] != adp_act);
	assign cov_wake = wake_source_config[`WSPG_WC_COVER] & (cov == cov_act)
		& (prev[1] != cov_act);
	assign btn_wake = btn & ~prev[2];
	assign any_wake = device_off & (adp_wake | cov_wake | btn_wake);

	always_comb
	begin
		next_wake_cfg  = wake_source_config;
		next_wake_stat = wake_cause_status;
		next_pg_cfg    = power_good_pin_config;
		if (reg_wr)
		begin
			case (reg_addr)
				`WSPG_ADDR_WAKE_CFG:  next_wake_cfg = reg_wdata[3:0];
				`WSPG_ADDR_WAKE_STAT: next_wake_stat = wake_cause_status & ~reg_wdata[3:0];
				`WSPG_ADDR_PG_CFG:    next_pg_cfg = reg_wdata[6:0];
				default:              next_wake_cfg = wake_source_config;
			endcase
		end
		// set wins over a clear in the same cycle
		if (any_wake & adp_wake)
			next_wake_stat[`WSPG_WS_ADAPTER] = 1'b1;
		if (any_wake & cov_wake)
			next_wake_stat[`WSPG_WS_COVER] = 1'b1;
		if (any_wake & btn_wake)
			next_wake_stat[`WSPG_WS_BUTTON] = 1'b1;
		if (thermal_shutdown)
			next_wake_stat[`WSPG_WS_THERMAL] = 1'b1;
		case (reg_addr)
			`WSPG_ADDR_WAKE_CFG:  next_rd_data = {4'h0, wake_source_config};
			`WSPG_ADDR_WAKE_STAT: next_rd_data = {4'h0, wake_cause_status};
			`WSPG_ADDR_PG_CFG:    next_rd_data = {1'b0, power_good_pin_config};
			default:              next_rd_data = 8'h00;
		endcase
		next_wake_req = any_wake;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			wake_source_config    <= `WSPG_WAKE_CFG_RST;
			wake_cause_status     <= `WSPG_WAKE_STAT_RST;
			power_good_pin_config <= `WSPG_PG_CFG_RST;
			reg_rd_data           <= 8'h00;
			wake_request          <= 1'b0;
		end
		else
		begin
			wake_source_config    <= next_wake_cfg;
			wake_cause_status     <= next_wake_stat;
			power_good_pin_config <= next_pg_cfg;
			reg_rd_data           <= next_rd_data;
			wake_request          <= next_wake_req;
		end
	end

	// ==========================================================
	// event flag sources
	logic [5:0] evt;
	logic       any_evt;

	always_comb
	begin
		evt[0] = (adp == adapter_polarity);
		evt[1] = (cov == int_cover_polarity);
		evt[2] = |(gpio_cfg.int_en & ~(gpio ^ gpio_cfg.pol));
		evt[3] = mon.overtemp;
		evt[4] = |mon.small_oc;
		evt[5] = mon.main_oc;
	end
	assign any_evt = |(evt & power_good_pin_config[5:0]);

	// ==========================================================
	// power-good pin sequencing
	wspg_state_type state;
	wspg_state_type next_state;
	logic [9:0]     hold_cnt;
	logic [9:0]     next_hold_cnt;
	logic           next_pg;

	always_comb
	begin
		next_state    = state;
		next_hold_cnt = 10'h000;
		next_pg       = 1'b0;
		case (state)
			WSPG_OFF:
			begin
				if (!device_off)
					next_state = power_good_pin_config[`WSPG_PG_MODE] ? WSPG_HOLD : WSPG_RAIL;
			end
			WSPG_RAIL:
			begin
				next_pg = rails_good;
				if (device_off)
					next_state = WSPG_OFF;
			end
			WSPG_HOLD:
			begin
				next_hold_cnt = hold_cnt + 10'h001;
				if (device_off)
					next_state = WSPG_OFF;
				else if (hold_cnt == HOLD_LAST)
					next_state = WSPG_FLAG;
			end
			WSPG_FLAG:
			begin
				// mode bit is no longer looked at here
				next_pg = ~any_evt;
				if (device_off)
					next_state = WSPG_OFF;
			end
			default:
				next_state = WSPG_OFF;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			state          <= WSPG_OFF;
			hold_cnt       <= 10'h000;
			power_good_pin <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			hold_cnt       <= next_hold_cnt;
			power_good_pin <= next_pg;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_ADP_WAKE: assert property (
		device_off && wake_source_config[0] && adp == ~adapter_polarity
		&& prev[0] == adapter_polarity |=> wake_request)
		else $error("adapter edge did not wake");
	AST_COV_WAKE: assert property (
		device_off && wake_source_config[1] && cov != wake_source_config[2]
		&& prev[1] == wake_source_config[2] |=> wake_request)
		else $error("cover edge did not wake");
	AST_COV_POL: assert property (
		device_off && wake_source_config[1:0] == 2'b10 && !wake_source_config[2]
		&& !cov && prev[1] && !(btn && !prev[2]) |=> !wake_request)
		else $error("cover fall woke while cover is high active");
	AST_ADP_STAT: assert property (
		any_wake && adp_wake |=> wake_cause_status[0])
		else $error("adapter status not set");
	AST_COV_STAT: assert property (
		any_wake && cov_wake |=> wake_cause_status[1])
		else $error("cover status not set");
	AST_BTN_STAT: assert property (
		device_off && btn && !prev[2] |=> wake_cause_status[2] && wake_request)
		else $error("button status not set");
	AST_THERM: assert property (
		thermal_shutdown |=> wake_cause_status[3])
		else $error("thermal status not set");
	AST_W1C: assert property (
		reg_wr && reg_addr == 8'h78 && reg_wdata[3] && !thermal_shutdown
		|=> !wake_cause_status[3])
		else $error("status not cleared");
	AST_W0: assert property (
		reg_wr && reg_addr == 8'h78 && !reg_wdata[0] && wake_cause_status[0]
		|=> wake_cause_status[0])
		else $error("zero write changed status");
	AST_RAIL: assert property (
		state == WSPG_RAIL && !device_off |=> power_good_pin == $past(rails_good))
		else $error("rail indicator wrong");
	AST_HOLD: assert property (
		$rose(state == WSPG_HOLD) ##1 !device_off [*8] |-> !power_good_pin)
		else $error("pin rose during hold");
	// the hold length is proven in steps: start at zero, one per cycle, leave at the last
	AST_HOLD_START: assert property (
		state == WSPG_OFF && !device_off && power_good_pin_config[6]
		|=> state == WSPG_HOLD && hold_cnt == 10'h000)
		else $error("hold did not start from zero");
	AST_HOLD_STEP: assert property (
		state == WSPG_HOLD && !device_off && hold_cnt != HOLD_LAST
		|=> state == WSPG_HOLD && hold_cnt == $past(hold_cnt) + 10'h001)
		else $error("hold ended early or its count skipped");
	AST_HOLD_CNT: assert property (
		state == WSPG_HOLD |-> hold_cnt <= HOLD_LAST)
		else $error("hold count ran past its end");
	AST_HOLD_END: assert property (
		state == WSPG_HOLD && !device_off && hold_cnt == HOLD_LAST |=> state == WSPG_FLAG)
		else $error("hold did not end at its last count");
	AST_FLAG: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[5] && mon.main_oc
		|=> !power_good_pin)
		else $error("main over-current not flagged");
	AST_SMALL_OC: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[4] && |mon.small_oc
		|=> !power_good_pin)
		else $error("small converter over-current not flagged");
	AST_OVERTEMPERATURE_FLAG_ENABLE_FLAG: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[3] && mon.overtemp
		|=> !power_good_pin)
		else $error("over-temperature not flagged");
	AST_ADP_FLAG: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[0]
		&& adp == adapter_polarity |=> !power_good_pin)
		else $error("adapter level not flagged");
	AST_COV_FLAG: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[1]
		&& cov == int_cover_polarity |=> !power_good_pin)
		else $error("cover level not flagged");
	AST_QUIET: assert property (
		state == WSPG_FLAG && !device_off && power_good_pin_config[5:0] == 6'h00
		|=> power_good_pin)
		else $error("pin low with no source enabled");
	AST_OFF_LOW: assert property (
		state == WSPG_OFF |=> !power_good_pin)
		else $error("pin high while off");
	AST_NO_WAKE_ON: assert property (
		!device_off |=> !wake_request)
		else $error("wake requested while already on");
endmodule

//--- verification/wspg_rail_model.sv
`timescale 1ns/1ps
module wspg_rail_model
(
	input  wire logic       mclk,
	input  wire logic       device_off,
	input  wire logic [7:0] ramp,
	output logic            rails_good
);
	// rails report good only after a ramp, and never while off
	logic [7:0] cnt = 8'h00;
	always_ff @(posedge mclk)
		cnt <= device_off ? 8'h00 : (cnt == ramp ? cnt : cnt + 8'h01);
	assign rails_good = !device_off && cnt == ramp;
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
	import wspg_pkg::*;
	logic              mclk = 1'b0;
	logic              rst_b = 1'b0;
	logic              reg_wr = 1'b0;
	logic              button = 1'b0;
	logic              thermal = 1'b0;
	logic              device_off = 1'b1;
	logic              pol = 1'b0;
	logic [7:0]        reg_addr = 8'h00;
	logic [7:0]        reg_wdata = 8'h00;
	logic [7:0]        ramp = 8'h05;
	logic [7:0]        n_wake = 8'h00;
	logic [5:0]        ev = 6'h00;
	logic [2:0]        oc_sel = 3'b001;
	logic [5:0]        idle;
	logic [7:0]        reg_rd_data;
	logic              wake_request;
	logic              power_good_pin;
	logic              rails_good;
	int                n_fail = 0;
	int                n_compared = 0;
	logic [9:0]        notes[$];
	event              got;
	wspg_gpio_cfg_type gpio_cfg = '{int_en: 8'h01, pol: 8'h00};
	wspg_mon_type      mon;
	assign mon = '{main_oc: ev[5], small_oc: (ev[4] ? oc_sel : 3'b000), overtemp: ev[3]};
	always #50 mclk = ~mclk;
	always @(posedge mclk)
		if (wake_request === 1'b1)
			n_wake <= n_wake + 8'h01;
	wspg_top dut_u
	(
		.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
		.adapter_present_input(ev[0]), .cover_switch_input(ev[1]),
		.power_button(button), .gpio_pin({7'h00, ev[2]}),
		.adapter_polarity(pol), .int_cover_polarity(pol), .gpio_cfg(gpio_cfg),
		.mon(mon), .thermal_shutdown(thermal), .device_off(device_off),
		.rails_good(rails_good), .wake_request(wake_request),
		.power_good_pin(power_good_pin)
	);
	wspg_rail_model rail_u
	(
		.mclk(mclk), .device_off(device_off), .ramp(ramp), .rails_good(rails_good)
	);
	// ==========================================================
	// bus tasks and scoreboard
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask
	// sel 0 read data, 1 pin, 2 wake pulse count
	task automatic chk(input logic [1:0] s, input logic [7:0] e);
		@(negedge mclk);
		notes.push_back({s, e});
		-> got;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		chk(2'd0, e);
	endtask
	always @(got)
	begin
		logic [9:0] n;
		logic [7:0] o;
		n = notes.pop_front();
		o = n[9:8] == 2'd0 ? reg_rd_data : n[9:8] == 2'd1 ? {7'h00, power_good_pin} : n_wake;
		n_compared++;
		if (o !== n[7:0])
		begin
			n_fail++;
			$display("BAD %0t sel %0d got %h want %h", $time, n[9:8], o, n[7:0]);
		end
	end
	task automatic stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_fail++;
		stop_test();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(84640));
		cyc(10);
		rst_b = 1'b1;
		rd(8'h77, 8'h03);
		rd(8'h78, 8'h00);
		rd(8'h79, 8'h60);
		rd(8'h7A, 8'h00);
		ev = 6'h01;
		cyc(5);
		rd(8'h78, 8'h01);
		ev = 6'h03;
		cyc(5);
		rd(8'h78, 8'h03);
		button = 1'b1;
		cyc(5);
		button = 1'b0;
		rd(8'h78, 8'h07);
		thermal = 1'b1;
		cyc(1);
		thermal = 1'b0;
		rd(8'h78, 8'h0F);
		chk(2'd2, 8'h03);
		wr(8'h78, 8'h00);
		rd(8'h78, 8'h0F);
		wr(8'h78, 8'h05);
		rd(8'h78, 8'h0A);
		wr(8'h78, 8'h0A);
		rd(8'h78, 8'h00);
		// sources disabled: edges must not wake
		wr(8'h77, 8'h00);
		ev = 6'h00;
		cyc(5);
		ev = 6'h03;
		cyc(5);
		rd(8'h78, 8'h00);
		// cover enabled but high active: a fall must not wake
		wr(8'h77, 8'h02);
		ev = 6'h01;
		cyc(5);
		rd(8'h78, 8'h00);
		wr(8'h77, 8'h06);
		rd(8'h77, 8'h06);
		ev = 6'h03;
		cyc(5);
		ev = 6'h01;
		cyc(5);
		rd(8'h78, 8'h02);
		chk(2'd2, 8'h04);
		wr(8'h79, 8'h00);
		ramp = 8'($urandom_range(30, 8));
		device_off = 1'b0;
		cyc(4);
		chk(2'd1, 8'h00);
		cyc(ramp);
		chk(2'd1, 8'h01);
		device_off = 1'b1;
		wr(8'h79, 8'h40);
		ev = 6'h07;
		device_off = 1'b0;
		cyc(900);
		chk(2'd1, 8'h00);
		wr(8'h79, 8'h00);
		cyc(80);
		chk(2'd1, 8'h00);
		cyc(30);
		chk(2'd1, 8'h01);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 6; i++)
			begin
				pol = p[0];
				oc_sel = 3'(1 << $urandom_range(2, 0));
				idle = {4'h1, {2{~pol}}};
				wr(8'h79, 8'(1 << i));
				ev = idle;
				cyc(5);
				chk(2'd1, 8'h01);
				ev = idle ^ 6'(1 << i);
				cyc(5);
				chk(2'd1, 8'h00);
			end
		stop_test();
	end
endmodule
